// file: dma_program_engine_addr_adjust.sv
// Contract
// - A read beat whose bytes wrap the bus width goes into two buffer lines.
// - Zero lane offset between source and destination never splits a beat.
// - Offsets that are multiples of source size never split a beat.
// - A split beat on channels 1-7 after one idle cycle holding a channel 0 update, following a split beat on the same channel, is flagged.
// - The shared interrupt carries no channel identity.
// - Launch only in manager; end, nop, event ops anywhere; rest channel-only.
// - Add-negative-halfword one-extends its 16-bit immediate to 32 bits.
// - The 32-bit address sum drops its carry and wraps through zero.
// - Opcode byte 0101_11r0, then immediate low byte, then high byte.
// - Select bit 0 targets source address, 1 targets destination address.
// - A fixed burst misaligned to its burst size is a programming error.
`timescale 1ns/1ps
`default_nettype none
`include "dma_adj_regs.svh"

module dma_program_engine_addr_adjust
(
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  input  wire logic                instr_valid,
  input  wire dma_adj_pkg::instr_t instr,
  input  wire logic                beat_valid,
  input  wire logic [2:0]          beat_chan,
  output logic                     instr_done,
  output logic                     instr_fault,
  output logic                     beat_split,
  output logic                     beat_error,
  output logic                     irq
);

  // ==========================================================
  // Channel state
  logic [31:0]            sar      [8];
  logic [31:0]            dar      [8];
  dma_adj_pkg::chan_cfg_t cfg      [8];
  logic [`ST_WIDTH-1:0]   status;
  logic [`ST_WIDTH-1:0]   mask;

  // ==========================================================
  // Register decode
  logic [2:0] reg_chan;
  logic       wr_sar;
  logic       wr_dar;
  logic       wr_cfg;
  logic       wr_status;
  logic       wr_mask;

  assign reg_chan  = reg_addr[`CHAN_MSB:`CHAN_LSB];
  assign wr_sar    = reg_wr && ((reg_addr & `GROUP_MASK) == `SAR_BASE);
  assign wr_dar    = reg_wr && ((reg_addr & `GROUP_MASK) == `DAR_BASE);
  assign wr_cfg    = reg_wr && ((reg_addr & `GROUP_MASK) == `CFG_BASE);
  assign wr_status = reg_wr && (reg_addr == `INT_STATUS);
  assign wr_mask   = reg_wr && (reg_addr == `INT_MASK);

  // ==========================================================
  // Instruction decode and thread check
  logic        is_adnh;
  logic        legal;
  logic        adnh_go;
  logic        adnh_dst;
  logic [31:0] imm_ext;
  logic [31:0] adnh_base;
  logic [31:0] adnh_sum;

  assign is_adnh  = (instr.b0 & `ADNH_MASK) == `ADNH_PATTERN;
  assign adnh_dst = instr.b0[`ADNH_SEL_BIT];

  always_comb
  begin
    if (is_adnh)
    begin
      legal = !instr.manager;
    end
    else
    begin
      case (instr.cls)
        dma_adj_pkg::channel_launch_op: legal = instr.manager;
        dma_adj_pkg::thread_end_op,
        dma_adj_pkg::no_operation_op,
        dma_adj_pkg::send_event_op,
        dma_adj_pkg::wait_event_op:     legal = 1'b1;
        default:                        legal = !instr.manager;
      endcase
    end
  end

  assign adnh_go = instr_valid && is_adnh && legal;

  // Low byte follows the opcode, high byte comes last
  assign imm_ext = {`ADNH_ONES, instr.b2, instr.b1};

  assign adnh_base = adnh_dst ? dar[instr.chan] : sar[instr.chan];

  // Carry is dropped on purpose: addresses wrap through zero
  assign adnh_sum = 32'(adnh_base + imm_ext);

  // ==========================================================
  // Address and configuration registers
  // An instruction in the same cycle as a bus write to the same
  // register wins, since it reflects the running program.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 8; i++)
      begin
        sar[i] <= `ADDR_RESET;
        dar[i] <= `ADDR_RESET;
      end
    end
    else
    begin
      if (wr_sar)
      begin
        sar[reg_chan] <= reg_wdata;
      end
      if (wr_dar)
      begin
        dar[reg_chan] <= reg_wdata;
      end
      if (adnh_go && !adnh_dst)
      begin
        sar[instr.chan] <= adnh_sum;
      end
      if (adnh_go && adnh_dst)
      begin
        dar[instr.chan] <= adnh_sum;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 8; i++)
      begin
        cfg[i] <= dma_adj_pkg::chan_cfg_t'(`CFG_RESET);
      end
    end
    else if (wr_cfg)
    begin
      cfg[reg_chan] <= dma_adj_pkg::chan_cfg_t'(reg_wdata[7:0]);
    end
  end

  // ==========================================================
  // Instruction result pulses
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      instr_done  <= 1'b0;
      instr_fault <= 1'b0;
    end
    else
    begin
      instr_done  <= instr_valid && legal;
      instr_fault <= instr_valid && !legal;
    end
  end

  // ==========================================================
  // Read beat lane check
  logic cur_split;
  logic cur_mis;

  lane_split_check u_split
  (
    .sar        (sar[beat_chan]),
    .dar        (dar[beat_chan]),
    .cfg        (cfg[beat_chan]),
    .split      (cur_split),
    .misaligned (cur_mis)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      beat_split <= 1'b0;
      beat_error <= 1'b0;
    end
    else
    begin
      // A misaligned fixed burst is refused, never placed
      beat_split <= beat_valid && cur_split && !cur_mis;
      beat_error <= beat_valid && cur_mis;
    end
  end

  // ==========================================================
  // Channel 0 update hazard watch
  logic       s1_valid;
  logic       s2_valid;
  logic       s2_split;
  logic [2:0] s2_chan;
  logic [2:0] s1_chan;
  logic       s1_split;
  logic       upd1;
  logic       upd0;
  logic       hazard;

  assign upd0 =
    ((wr_sar || wr_dar || wr_cfg) && (reg_chan == `CHAN_ZERO)) ||
    (adnh_go && (instr.chan == `CHAN_ZERO));

  // Second split beat after exactly one idle cycle holding a ch0 update
  assign hazard = beat_valid && cur_split && (beat_chan != `CHAN_ZERO) &&
                  !s1_valid && s2_valid && s2_split &&
                  (s2_chan == beat_chan) && upd1;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      s1_valid <= 1'b0;
      s1_split <= 1'b0;
      s1_chan  <= `CHAN_ZERO;
      s2_valid <= 1'b0;
      s2_split <= 1'b0;
      s2_chan  <= `CHAN_ZERO;
      upd1     <= 1'b0;
    end
    else
    begin
      s1_valid <= beat_valid;
      s1_split <= cur_split;
      s1_chan  <= beat_chan;
      s2_valid <= s1_valid;
      s2_split <= s1_split;
      s2_chan  <= s1_chan;
      upd1     <= upd0;
    end
  end

  // ==========================================================
  // Interrupt status and mask
  logic [`ST_WIDTH-1:0] next_status;
  logic [`ST_WIDTH-1:0] set_bits;

  always_comb
  begin
    set_bits = '0;
    set_bits[`ST_THREAD_FAULT] = instr_valid && !legal;
    set_bits[`ST_PROG_ERR]     = beat_valid && cur_mis;
    set_bits[`ST_HAZARD]       = hazard;
    set_bits[`ST_ADNH_DONE]    = adnh_go;
    next_status = status;
    if (wr_status)
    begin
      next_status = status & ~reg_wdata[`ST_WIDTH-1:0];
    end
    // Set beats clear so an event in the clearing cycle survives
    next_status = next_status | set_bits;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      status <= `STATUS_RESET;
    end
    else
    begin
      status <= next_status;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      mask <= `MASK_RESET;
    end
    else if (wr_mask)
    begin
      mask <= reg_wdata[`ST_WIDTH-1:0];
    end
  end

  // One shared line with no channel identity; software finds the
  // source from address progress
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(next_status & (wr_mask ? reg_wdata[`ST_WIDTH-1:0] : mask));
    end
  end

  // ==========================================================
  // Register read port
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      reg_rdata <= '0;
    end
    else if (reg_rd)
    begin
      if ((reg_addr & `GROUP_MASK) == `SAR_BASE)
      begin
        reg_rdata <= sar[reg_chan];
      end
      else if ((reg_addr & `GROUP_MASK) == `DAR_BASE)
      begin
        reg_rdata <= dar[reg_chan];
      end
      else if ((reg_addr & `GROUP_MASK) == `CFG_BASE)
      begin
        reg_rdata <= {24'h00_0000, cfg[reg_chan]};
      end
      else if (reg_addr == `INT_STATUS)
      begin
        reg_rdata <= {28'h000_0000, status};
      end
      else if (reg_addr == `INT_MASK)
      begin
        reg_rdata <= {28'h000_0000, mask};
      end
      else
      begin
        reg_rdata <= '0;
      end
    end
    else
    begin
      reg_rdata <= '0;
    end
  end

endmodule
`default_nettype wire

// file: dma_adj_regs.svh
`ifndef DMA_ADJ_REGS_SVH
`define DMA_ADJ_REGS_SVH

// ==========================================================
// Register map (byte addresses, channel index in addr[4:2])
`define SAR_BASE        8'h00
`define DAR_BASE        8'h20
`define CFG_BASE        8'h40
`define INT_STATUS      8'h60
`define INT_MASK        8'h64
`define GROUP_MASK      8'he3
`define CHAN_MSB        4
`define CHAN_LSB        2

// ==========================================================
// Interrupt status bit positions
`define ST_THREAD_FAULT 0
`define ST_PROG_ERR     1
`define ST_HAZARD       2
`define ST_ADNH_DONE    3
`define ST_WIDTH        4

// ==========================================================
// Reset values
`define ADDR_RESET      32'h0000_0000
`define CFG_RESET       8'h00
`define STATUS_RESET    4'h0
`define MASK_RESET      4'h0

// ==========================================================
// Add-negative-halfword opcode and immediate extension
`define ADNH_MASK       8'hfd
`define ADNH_PATTERN    8'h5c
`define ADNH_SEL_BIT    1
`define ADNH_ONES       16'hffff

// ==========================================================
// Buffer line of 16 bytes: lane offset is four bits
`define LANE_MSB        3
`define LANE_ONE        4'h1
`define CHAN_ZERO       3'h0

`endif

// file: dma_adj_pkg.sv
`default_nettype none
package dma_adj_pkg;

  typedef enum logic [2:0]
  {
    channel_launch_op,
    thread_end_op,
    no_operation_op,
    send_event_op,
    wait_event_op,
    channel_only_op
  } op_class_t;

  typedef enum logic [1:0]
  {
    source_size_byte,
    source_size_halfword,
    source_size_word,
    source_size_doubleword
  } xfer_size_t;

  typedef struct packed
  {
    logic       manager;
    logic [2:0] chan;
    op_class_t  cls;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } instr_t;

  typedef struct packed
  {
    logic       dst_inc;
    logic       src_inc;
    xfer_size_t dst_burst;
    xfer_size_t src_burst;
    xfer_size_t src_size;
  } chan_cfg_t;

endpackage
`default_nettype wire

// file: lane_split_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_adj_regs.svh"

module lane_split_check
(
  input  wire logic [31:0]           sar,
  input  wire logic [31:0]           dar,
  input  wire dma_adj_pkg::chan_cfg_t cfg,
  output logic                       split,
  output logic                       misaligned
);

  // ==========================================================
  // Lane mask of a transfer size
  function automatic logic [`LANE_MSB:0] size_mask
  (
    input dma_adj_pkg::xfer_size_t s
  );
    size_mask = 4'((`LANE_ONE << s) - `LANE_ONE);
  endfunction

  logic [`LANE_MSB:0] offset;

  // Offset wraps inside one line, so the subtraction is lane-modular
  assign offset = 4'(dar[`LANE_MSB:0] - sar[`LANE_MSB:0]);

  // Zero offset, or a multiple of source size, never splits
  assign split = |(offset & size_mask(cfg.src_size));

  // Fixed bursts must start aligned to their burst size
  assign misaligned =
    (!cfg.src_inc && |(sar[`LANE_MSB:0] & size_mask(cfg.src_burst))) ||
    (!cfg.dst_inc && |(dar[`LANE_MSB:0] & size_mask(cfg.dst_burst)));

endmodule
`default_nettype wire

// file: dma_adj_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_adj_regs.svh"
// ====
// Port checks
module dma_adj_checker
(
  input wire logic                core_clk,
  input wire logic                rstn,
  input wire logic                reg_wr,
  input wire logic                instr_valid,
  input wire dma_adj_pkg::instr_t instr,
  input wire logic                beat_valid,
  input wire logic                instr_done,
  input wire logic                instr_fault,
  input wire logic                beat_split,
  input wire logic                beat_error,
  input wire logic                irq
);
  logic adnh;
  logic launch;
  logic chonly;
  assign adnh   = (instr.b0 & `ADNH_MASK) == `ADNH_PATTERN;
  assign launch = instr.cls == dma_adj_pkg::channel_launch_op;
  assign chonly = instr.cls == dma_adj_pkg::channel_only_op;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  AST_LAUNCH: assert property (
    instr_valid && !adnh && launch |=> instr_done == $past(instr.manager)
    && instr_fault != $past(instr.manager))
    else $error("launch thread check");
  AST_MGR_REFUSE: assert property (
    instr_valid && instr.manager && (adnh || chonly)
    |=> instr_fault && !instr_done)
    else $error("manager ran channel op");
  AST_SHARED: assert property (
    instr_valid && !adnh && !launch && !chonly
    && instr.cls < dma_adj_pkg::channel_only_op
    |=> instr_done && !instr_fault)
    else $error("shared op refused");
  AST_ADNH: assert property (
    instr_valid && !instr.manager && adnh |=> instr_done)
    else $error("adnh not taken");
  AST_ANSWER: assert property (
    instr_done || instr_fault |-> $past(instr_valid)
    && !(instr_done && instr_fault))
    else $error("stray answer");
  AST_BEAT: assert property (
    beat_split || beat_error |-> $past(beat_valid))
    else $error("stray beat flag");
  AST_ERR_GATE: assert property (
    beat_error |-> !beat_split)
    else $error("split on bad beat");
  AST_IRQ_RISE: assert property (
    $rose(irq) |-> $past(instr_valid || beat_valid || reg_wr))
    else $error("irq without event");
endmodule
bind dma_program_engine_addr_adjust dma_adj_checker u_chk
(
  .core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr),
  .instr_valid(instr_valid), .instr(instr), .beat_valid(beat_valid),
  .instr_done(instr_done), .instr_fault(instr_fault),
  .beat_split(beat_split), .beat_error(beat_error), .irq(irq)
);
`default_nettype wire

// file: dma_adj_beat_source.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Read beat source in place of the interconnect
module dma_adj_beat_source
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic       pair,
  input  wire logic [2:0] chan,
  output logic            beat_valid,
  output logic [2:0]      beat_chan
);
  logic [1:0] left;
  // Idle channel lines toggle so a stale value never looks valid
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      beat_valid <= 1'h0;
      beat_chan  <= 3'h0;
      left       <= 2'h0;
    end
    else if (start)
    begin
      beat_valid <= 1'h1;
      beat_chan  <= chan;
      left       <= {pair, 1'h0};
    end
    else
    begin
      beat_valid <= left == 2'h1;
      beat_chan  <= ~beat_chan;
      left       <= left >> 1;
    end
  end
endmodule
`default_nettype wire

// file: dma_program_engine_addr_adjust_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_adj_regs.svh"
// ====
// Self-checking bench
module dma_program_engine_addr_adjust_test;
  logic                core_clk, rstn, reg_wr, reg_rd, instr_valid, start;
  logic                beat_valid, instr_done, instr_fault, irq, pair;
  logic                beat_split, beat_error;
  logic [2:0]          pchan, beat_chan;
  logic [7:0]          reg_addr, loc;
  logic [31:0]         reg_wdata, reg_rdata, a;
  logic [15:0]         rnd, imm;
  dma_adj_pkg::instr_t instr;
  int                  n_mismatch, tests_run;

  dma_program_engine_addr_adjust DUT
  (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_valid(instr_valid), .instr(instr),
    .beat_valid(beat_valid), .beat_chan(beat_chan),
    .instr_done(instr_done), .instr_fault(instr_fault),
    .beat_split(beat_split), .beat_error(beat_error), .irq(irq)
  );
  dma_adj_beat_source far_end
  (
    .core_clk(core_clk), .rstn(rstn), .start(start), .pair(pair),
    .chan(pchan), .beat_valid(beat_valid), .beat_chan(beat_chan)
  );

  // ====
  // Expectations
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic split_of(input int sz, input int off);
    return (off % (1 << sz)) != 0;
  endfunction
  function automatic logic ok_in(input logic m, input int c);
    return c == 0 ? m : (c == 5 ? !m : 1'h1);
  endfunction
  // Carry falls off the top, so low addresses wrap to the top
  function automatic logic [31:0] add_neg(input logic [31:0] v,
                                          input logic [15:0] k);
    return v + {16'hffff, k};
  endfunction

  // ====
  // Bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    reg_addr <= ad;
    reg_rd   <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
    @(posedge core_clk);
  endtask
  task automatic ins(input logic m, input logic [2:0] ch, input int c,
                     input logic [7:0] op, input logic [15:0] k,
                     input logic ok);
    instr       <= {m, ch, c[2:0], k, op};
    instr_valid <= 1'h1;
    @(posedge core_clk);
    instr_valid <= 1'h0;
    #1 chk(32'({instr_done, instr_fault}), 32'({ok, !ok}));
    @(posedge core_clk);
  endtask
  task automatic bt(input logic [2:0] ch, input logic sp, input logic er);
    start <= 1'h1;
    pair  <= 1'h0;
    pchan <= ch;
    @(posedge core_clk);
    start <= 1'h0;
    @(posedge core_clk);
    #1 chk(32'({beat_split, beat_error}), 32'({sp, er}));
    @(posedge core_clk);
  endtask
  // Level output is looked at after the edge has settled it
  task automatic ck_irq(input logic [31:0] exp);
    #1 chk(32'(irq), exp);
    @(posedge core_clk);
  endtask
  // Two split beats on channel 1 with one idle cycle between them;
  // how[0] puts a channel 0 bus write, how[1] a channel 0 adjust,
  // into that idle cycle
  task automatic hz(input logic [1:0] how, input logic [31:0] exp);
    start <= 1'h1;
    pair  <= 1'h1;
    pchan <= 3'h1;
    @(posedge core_clk);
    start <= 1'h0;
    @(posedge core_clk);
    reg_addr    <= `SAR_BASE;
    reg_wdata   <= 32'h4;
    reg_wr      <= how[0];
    instr       <= {1'h0, 3'h0, 3'h5, 16'hfff0, 8'h5c};
    instr_valid <= how[1];
    @(posedge core_clk);
    reg_wr      <= 1'h0;
    instr_valid <= 1'h0;
    repeat (2) @(posedge core_clk);
    rd(`INT_STATUS, exp);
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ====
  // Clock, watchdog, sequence
  initial
  begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    #200000 n_mismatch++;
    give_verdict();
  end
  initial
  begin
    {rstn, reg_wr, reg_rd, instr_valid, start, pair} = 6'h0;
    {pchan, reg_addr, reg_wdata, instr} = '0;
    n_mismatch = 0;
    tests_run = 0;
    rnd = 16'hd442;
    repeat (2) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    rd(`INT_STATUS, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rd(8'h80, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      a   = i == 0 ? 32'h10 : {rnd, ~rnd};
      imm = i == 0 ? 16'hfff0 : rnd;
      loc = (i[0] ? `DAR_BASE : `SAR_BASE) + 8'(i * 4);
      wr(loc, a);
      ins(1'h0, i[2:0], 5, {6'h17, i[0], 1'h0}, imm, 1'h1);
      rd(loc, add_neg(a, imm));
      rd(loc ^ 8'h20, 32'h0);
    end
    $display("address adjust test done");
    for (int c = 0; c < 6; c++)
      for (int m = 0; m < 2; m++)
        ins(m[0], 3'h3, c, 8'h00, 16'h0, ok_in(m[0], c));
    ins(1'h1, 3'h3, 5, 8'h5e, 16'hffff, 1'h0);
    $display("thread usage test done");
    for (int sz = 0; sz < 4; sz++)
    begin
      rnd = lfsr(rnd);
      wr(`CFG_BASE + 8'h4, 32'hc0 + 32'(sz));
      wr(`SAR_BASE + 8'h4, {16'h0, rnd});
      for (int o = 0; o < 16; o++)
      begin
        wr(`DAR_BASE + 8'h4, {16'h0, rnd} + 32'(o));
        bt(3'h1, split_of(sz, o), 1'h0);
      end
    end
    $display("split test done");
    wr(`INT_STATUS, 32'hf);
    wr(`CFG_BASE + 8'h4, 32'h8);
    wr(`SAR_BASE + 8'h4, 32'h2);
    bt(3'h1, 1'h0, 1'h1);
    wr(`SAR_BASE + 8'h4, 32'h4);
    bt(3'h1, 1'h0, 1'h0);
    wr(`CFG_BASE + 8'h4, 32'h20);
    wr(`DAR_BASE + 8'h4, 32'h6);
    bt(3'h1, 1'h0, 1'h1);
    rd(`INT_STATUS, 32'h2);
    $display("fixed burst test done");
    wr(`CFG_BASE + 8'h4, 32'hc2);
    wr(`DAR_BASE + 8'h4, 32'h1);
    wr(`INT_STATUS, 32'hf);
    hz(2'h0, 32'h0);
    hz(2'h2, 32'hc);
    wr(`INT_STATUS, 32'hf);
    hz(2'h1, 32'h4);
    wr(`INT_MASK, 32'hf);
    ck_irq(32'h1);
    wr(`INT_MASK, 32'h0);
    ck_irq(32'h0);
    wr(`INT_STATUS, 32'h4);
    rd(`INT_STATUS, 32'h0);
    wr(`INT_MASK, 32'hf);
    ck_irq(32'h0);
    $display("hazard and interrupt test done");
    give_verdict();
  end
endmodule
`default_nettype wire
